/* File: rtl/hap_pkg.sv */
// shared constants and types of the host access port
package hap_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W  = 15;
  localparam int DATA_W  = 8;
  localparam int IADDR_W = 16;
  localparam int CNT_W   = 6;
  localparam int FRAME_W = 32;
  localparam int SYNC_W  = 4 + ADDR_W + DATA_W;

  // ---------------------------------------------------------------------------
  // indirect local map and mode control fields
  // ---------------------------------------------------------------------------
  localparam logic [1:0]         LOC_MODE      = 2'h0;
  localparam logic [1:0]         LOC_ADDR_HI   = 2'h1;
  localparam logic [1:0]         LOC_ADDR_LO   = 2'h2;
  localparam logic [1:0]         LOC_DATA      = 2'h3;
  localparam logic [IADDR_W-1:0] MODE_REG_ADDR = 16'h0000;
  localparam int                 MODE_IND_BIT  = 0;
  localparam int                 MODE_AI_BIT   = 1;
  localparam logic [DATA_W-1:0]  MODE_RESET    = 8'h00;
  localparam logic [IADDR_W-1:0] AI_STEP       = 16'h0001;
  localparam logic [IADDR_W-1:0] IDX_RESET     = 16'h0000;

  // ---------------------------------------------------------------------------
  // serial frame
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] OP_WRITE   = 8'hF0;
  localparam logic [DATA_W-1:0] OP_READ    = 8'h0F;
  localparam logic [CNT_W-1:0]  HDR_LAST   = 6'h17;
  localparam logic [CNT_W-1:0]  FRAME_LAST = 6'h1F;
  localparam int                SCLK_PIN   = 14;
  localparam int                SS_PIN     = 13;
  localparam int                MOSI_PIN   = 12;

  // pin levels assumed while in reset: strobes and slave select idle high
  localparam logic [SYNC_W-1:0] PIN_IDLE = 27'h3A00000;

  typedef enum {P_IDLE, P_BUSY, P_HOLD} hap_pst_t;

endpackage : hap_pkg

/* File: rtl/hap_host_access_port.sv */
// host access port: direct/indirect parallel bus and mode 0 serial slave
`timescale 1ns/1ns
module hap_host_access_port
  import hap_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  // host pins
  input  wire logic               spi_en_i,
  input  wire logic               cs_n_i,
  input  wire logic               rd_n_i,
  input  wire logic               wr_n_i,
  input  wire logic [ADDR_W-1:0]  addr_i,
  input  wire logic [DATA_W-1:0]  data_i,
  output logic      [DATA_W-1:0]  data_o,
  output logic                    data_oe_n_o,
  output logic                    int_n_o,
  output logic                    miso_o,
  output logic                    miso_oe_n_o,
  // internal register and buffer port
  output logic      [IADDR_W-1:0] mem_addr_o,
  output logic      [DATA_W-1:0]  mem_wdata_o,
  output logic                    mem_we_o,
  output logic                    mem_re_o,
  input  wire logic [DATA_W-1:0]  mem_rdata_i,
  input  wire logic               irq_i
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [SYNC_W-1:0] s1_reg, s2_reg;
  logic              sclk_d_reg;
  logic              sp_en, cs_n, rd_n, wr_n, sclk, ss_n, mosi;
  logic [ADDR_W-1:0] pa;
  logic [DATA_W-1:0] pd;
  logic              sclk_rise, sclk_fall;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s1_reg     <= PIN_IDLE;
      s2_reg     <= PIN_IDLE;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg     <= {spi_en_i, cs_n_i, rd_n_i, wr_n_i, addr_i, data_i};
      s2_reg     <= s1_reg;
      sclk_d_reg <= sclk;
    end
  end

  assign sp_en = s2_reg[SYNC_W-1];
  assign cs_n  = s2_reg[SYNC_W-2];
  assign rd_n  = s2_reg[SYNC_W-3];
  assign wr_n  = s2_reg[SYNC_W-4];
  assign pa    = s2_reg[DATA_W +: ADDR_W];
  assign pd    = s2_reg[DATA_W-1:0];
  // address pins double as serial pins
  assign sclk  = pa[SCLK_PIN];
  assign ss_n  = pa[SS_PIN];
  assign mosi  = pa[MOSI_PIN];
  // mode 0: clock idles low, sample on rise, shift on fall
  assign sclk_rise = sp_en & ~ss_n & sclk & ~sclk_d_reg;
  assign sclk_fall = sp_en & ~ss_n & ~sclk & sclk_d_reg;

  // ---------------------------------------------------------------------------
  // shared request and response path
  // ---------------------------------------------------------------------------
  logic               req, req_wr;
  logic [IADDR_W-1:0] req_addr;
  logic [DATA_W-1:0]  req_wdata;
  logic               rsp_valid;
  logic [DATA_W-1:0]  rsp_data;

  // ---------------------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0]   cnt_reg, cnt_next;
  logic [FRAME_W-1:0] rx_reg, rx_next, rx_shift;
  logic [DATA_W-1:0]  tx_reg, tx_next;
  logic               miso_reg, miso_next;
  logic               sread_reg, sread_next;
  logic               spi_req, spi_wr;
  logic [IADDR_W-1:0] spi_addr;

  always_comb
  begin
    cnt_next   = cnt_reg;
    rx_next    = rx_reg;
    tx_next    = tx_reg;
    miso_next  = miso_reg;
    sread_next = sread_reg;
    spi_req    = 1'b0;
    spi_wr     = 1'b0;
    spi_addr   = rx_reg[DATA_W +: IADDR_W];
    rx_shift   = {rx_reg[FRAME_W-2:0], mosi};
    if (!sp_en || ss_n)
    begin
      cnt_next   = '0;
      sread_next = 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        rx_next  = rx_shift;
        cnt_next = cnt_reg + 6'h01;
        if (cnt_reg == HDR_LAST && rx_shift[2*DATA_W +: DATA_W] == OP_READ)
        begin
          spi_req    = 1'b1;
          spi_addr   = rx_shift[IADDR_W-1:0];
          sread_next = 1'b1;
        end
        if (cnt_reg == FRAME_LAST)
        begin
          cnt_next   = '0;
          sread_next = 1'b0;
          if (rx_shift[FRAME_W-1 -: DATA_W] == OP_WRITE)
          begin
            spi_req  = 1'b1;
            spi_wr   = 1'b1;
            spi_addr = rx_shift[DATA_W +: IADDR_W];
          end
        end
      end
      if (sclk_fall)
      begin
        miso_next = tx_reg[DATA_W-1];
        tx_next   = {tx_reg[DATA_W-2:0], 1'b0};
      end
    end
    if (sp_en && rsp_valid && sread_reg)
      tx_next = rsp_data;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cnt_reg   <= '0;
      rx_reg    <= '0;
      tx_reg    <= '0;
      miso_reg  <= 1'b0;
      sread_reg <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      rx_reg    <= rx_next;
      tx_reg    <= tx_next;
      miso_reg  <= miso_next;
      sread_reg <= sread_next;
    end
  end

  assign miso_o      = miso_reg;
  assign miso_oe_n_o = ~(sp_en & ~ss_n);

  // ---------------------------------------------------------------------------
  // parallel bus, mode control and request register
  // ---------------------------------------------------------------------------
  hap_pst_t           pst_reg, pst_next;
  logic [DATA_W-1:0]  mode_reg, mode_next, dout_reg, dout_next;
  logic [IADDR_W-1:0] idx_reg, idx_next, raddr_reg, raddr_next;
  logic [DATA_W-1:0]  rwd_reg, rwd_next;
  logic               rdc_reg, rdc_next, rwe_reg, rwe_next, rre_reg, rre_next;
  logic               rloc_reg, rloc_next, rpend_reg, rpend_next, rmode_reg, rmode_next;
  logic               int_n_reg;
  logic               par_req, par_wr, cs_act, ind, ai;
  logic [IADDR_W-1:0] par_addr;

  assign ind       = mode_reg[MODE_IND_BIT];
  assign ai        = mode_reg[MODE_AI_BIT];
  assign cs_act    = ~sp_en & ~cs_n & (~rd_n | ~wr_n);
  assign rsp_valid = rpend_reg;
  assign rsp_data  = rmode_reg ? mode_reg : mem_rdata_i;

  always_comb
  begin
    pst_next  = pst_reg;
    dout_next = dout_reg;
    idx_next  = idx_reg;
    rdc_next  = rdc_reg;
    mode_next = mode_reg;
    par_req   = 1'b0;
    par_wr    = rd_n;
    par_addr  = {1'b0, pa};
    case (pst_reg)
      P_IDLE:
      begin
        if (cs_act)
        begin
          rdc_next = ~rd_n;
          pst_next = P_HOLD;
          if (!ind)
            par_req = 1'b1;
          else
          begin
            case (pa[1:0])
              LOC_MODE:
              begin
                par_req  = 1'b1;
                par_addr = MODE_REG_ADDR;
              end
              LOC_ADDR_HI:
              begin
                if (!rd_n)
                  dout_next = idx_reg[IADDR_W-1 -: DATA_W];
                else
                  idx_next[IADDR_W-1 -: DATA_W] = pd;
              end
              LOC_ADDR_LO:
              begin
                if (!rd_n)
                  dout_next = idx_reg[DATA_W-1:0];
                else
                  idx_next[DATA_W-1:0] = pd;
              end
              default:
              begin
                par_req  = 1'b1;
                par_addr = idx_reg;
                if (ai)
                  idx_next = idx_reg + AI_STEP;
              end
            endcase
          end
          if (par_req && !rd_n)
            pst_next = P_BUSY;
        end
      end
      P_BUSY:
      begin
        if (rsp_valid)
        begin
          dout_next = rsp_data;
          pst_next  = P_HOLD;
        end
      end
      P_HOLD:
      begin
        if (cs_n || (rd_n && wr_n))
        begin
          pst_next = P_IDLE;
          rdc_next = 1'b0;
        end
      end
      default:
        pst_next = P_IDLE;
    endcase
    req       = sp_en ? spi_req : par_req;
    req_wr    = sp_en ? spi_wr : par_wr;
    req_addr  = sp_en ? spi_addr : par_addr;
    req_wdata = sp_en ? rx_shift[DATA_W-1:0] : pd;
    rwe_next   = req & req_wr;
    rre_next   = req & ~req_wr;
    rloc_next  = (req_addr == MODE_REG_ADDR);
    raddr_next = req ? req_addr : raddr_reg;
    rwd_next   = req ? req_wdata : rwd_reg;
    rpend_next = rre_reg;
    rmode_next = rloc_reg;
    if (rwe_next && rloc_next)
      mode_next = req_wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pst_reg   <= P_IDLE;
      mode_reg  <= MODE_RESET;
      dout_reg  <= '0;
      idx_reg   <= IDX_RESET;
      rdc_reg   <= 1'b0;
      raddr_reg <= '0;
      rwd_reg   <= '0;
      rwe_reg   <= 1'b0;
      rre_reg   <= 1'b0;
      rloc_reg  <= 1'b0;
      rpend_reg <= 1'b0;
      rmode_reg <= 1'b0;
      int_n_reg <= 1'b1;
    end
    else
    begin
      pst_reg   <= pst_next;
      mode_reg  <= mode_next;
      dout_reg  <= dout_next;
      idx_reg   <= idx_next;
      rdc_reg   <= rdc_next;
      raddr_reg <= raddr_next;
      rwd_reg   <= rwd_next;
      rwe_reg   <= rwe_next;
      rre_reg   <= rre_next;
      rloc_reg  <= rloc_next;
      rpend_reg <= rpend_next;
      rmode_reg <= rmode_next;
      int_n_reg <= ~irq_i;
    end
  end

  assign data_o      = dout_reg;
  assign data_oe_n_o = ~((pst_reg == P_HOLD) & rdc_reg);
  assign int_n_o     = int_n_reg;
  assign mem_addr_o  = raddr_reg;
  assign mem_wdata_o = rwd_reg;
  assign mem_we_o    = rwe_reg & ~rloc_reg;
  assign mem_re_o    = rre_reg & ~rloc_reg;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_hdr_read;
    sclk_rise && cnt_reg == HDR_LAST && rx_shift[2*DATA_W +: DATA_W] == OP_READ;
  endsequence
  sequence s_frame_end;
    sclk_rise && cnt_reg == FRAME_LAST;
  endsequence

  property p_direct_read;
    (pst_reg == P_IDLE && cs_act && !ind && !rd_n && pa != '0)
      |=> mem_re_o && mem_addr_o == {1'b0, $past(pa)} ##1 rsp_valid ##1 dout_reg == $past(mem_rdata_i);
  endproperty
  a_direct_read: assert property (p_direct_read) else $error("direct read path wrong");

  property p_ind_data;
    (pst_reg == P_IDLE && cs_act && ind && pa[1:0] == LOC_DATA)
      |=> mem_addr_o == $past(idx_reg) && (mem_we_o || mem_re_o);
  endproperty
  a_ind_data: assert property (p_ind_data) else $error("data port not at held address");

  property p_addr_hi;
    (pst_reg == P_IDLE && cs_act && ind && rd_n && pa[1:0] == LOC_ADDR_HI)
      |=> idx_reg[IADDR_W-1 -: DATA_W] == $past(pd)
          && idx_reg[DATA_W-1:0] == $past(idx_reg[DATA_W-1:0]);
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("high address byte not loaded");

  property p_auto_inc;
    (pst_reg == P_IDLE && cs_act && ind && pa[1:0] == LOC_DATA)
      |=> idx_reg == $past(idx_reg) + ($past(ai) ? AI_STEP : '0);
  endproperty
  a_auto_inc: assert property (p_auto_inc) else $error("auto increment wrong");

  property p_miso_en;
    miso_oe_n_o == !(sp_en && !ss_n);
  endproperty
  a_miso_en: assert property (p_miso_en) else $error("serial output enable wrong");

  property p_miso_fall;
    !$stable(miso_o) |-> $past(sclk_fall);
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("serial output moved off fall");

  property p_hdr_read;
    s_hdr_read |=> mem_addr_o == $past(rx_shift[IADDR_W-1:0]) && rre_reg
      ##2 tx_reg == $past(rsp_data);
  endproperty
  a_hdr_read: assert property (p_hdr_read) else $error("read frame not fetched");

  property p_bad_op;
    (s_frame_end and rx_shift[FRAME_W-1 -: DATA_W] != OP_WRITE) |=> !rwe_reg;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("write from wrong opcode");

  property p_write_end;
    (s_frame_end and rx_shift[FRAME_W-1 -: DATA_W] == OP_WRITE)
      |=> rwe_reg && mem_wdata_o == $past(rx_shift[DATA_W-1:0]) && cnt_reg == '0;
  endproperty
  a_write_end: assert property (p_write_end) else $error("serial write not stored");

  property p_abort;
    (sp_en && ss_n) |=> cnt_reg == '0 && !rwe_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("partial frame not dropped");

endmodule : hap_host_access_port

/* File: test/hap_host_model.sv */
// host microcontroller model: parallel bus master and mode 0 serial master
`timescale 1ns/1ns
module hap_host_model
  import hap_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // answers from the device
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic              rdata_oe_n_i,
  input  wire logic              miso_i,
  input  wire logic              miso_oe_n_i,
  // host pins
  output logic                   spi_en_o,
  output logic                   cs_n_o,
  output logic                   rd_n_o,
  output logic                   wr_n_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o
);
  initial
  begin
    spi_en_o = 1'b0;
    cs_n_o   = 1'b1;
    rd_n_o   = 1'b1;
    wr_n_o   = 1'b1;
    addr_o   = 15'h0000;
    wdata_o  = 8'h00;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_cyc

  // strobe held 20 cycles, 80 ns
  task automatic par_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    cs_n_o  <= 1'b0;
    wr_n_o  <= 1'b0;
    wait_cyc(20);
    cs_n_o  <= 1'b1;
    wr_n_o  <= 1'b1;
    wdata_o <= ~d; // released data lines do not keep the value
    wait_cyc(10);
  endtask : par_wr

  task automatic par_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    wait_cyc(20);
    d = (rdata_oe_n_i === 1'b0) ? rdata_i : 8'hXX;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    wait_cyc(10);
  endtask : par_rd

  // select idles high, clock low
  task automatic spi_mode(input logic en);
    @(posedge clk_i);
    spi_en_o <= en;
    addr_o   <= 15'h2000;
    wait_cyc(10);
  endtask : spi_mode

  // mode 0: mosi set on fall, clock rises mid bit, miso taken before the rise
  task automatic spi_frame(input logic [7:0] op, input logic [IADDR_W-1:0] ia,
                           input logic [7:0] d, input int nbits, output logic [7:0] rx);
    logic [FRAME_W-1:0] f;
    f  = {op, ia, d};
    rx = 8'h00;
    @(posedge clk_i);
    addr_o[SS_PIN] <= 1'b0;
    wait_cyc(10);
    for (int i = FRAME_W - 1; i >= FRAME_W - nbits; i--)
    begin
      // clock low, select low, next bit on the data line in one step
      addr_o <= 15'(f[i]) << MOSI_PIN;
      wait_cyc(10);
      rx = {rx[6:0], (miso_oe_n_i === 1'b0) ? miso_i : 1'bx};
      addr_o[SCLK_PIN] <= 1'b1;
      wait_cyc(10);
    end
    addr_o[SCLK_PIN] <= 1'b0;
    wait_cyc(10);
    // select high, released data line drifts to the other level
    addr_o <= (15'(1'b1) << SS_PIN) | (15'(~addr_o[MOSI_PIN]) << MOSI_PIN);
    wait_cyc(10);
  endtask : spi_frame
endmodule : hap_host_model

/* File: test/tb_top.sv */
// self-checking bench of the host access port
`timescale 1ns/1ns
module tb_top;
  import hap_pkg::*;
  logic               clk_i;
  logic               rstn_i;
  logic               irq_i;
  logic               spi_en_i;
  logic               cs_n_i;
  logic               rd_n_i;
  logic               wr_n_i;
  logic [ADDR_W-1:0]  addr_i;
  logic [DATA_W-1:0]  data_i;
  logic [DATA_W-1:0]  data_o;
  logic               data_oe_n_o;
  logic               int_n_o;
  logic               miso_o;
  logic               miso_oe_n_o;
  logic [IADDR_W-1:0] mem_addr_o;
  logic [DATA_W-1:0]  mem_wdata_o;
  logic               mem_we_o;
  logic               mem_re_o;
  logic [DATA_W-1:0]  mem_rdata_i;
  logic [DATA_W-1:0]  rd;
  logic [DATA_W-1:0]  mem [logic [IADDR_W-1:0]];
  logic [DATA_W-1:0]  bad_ops [4] = '{8'h00, 8'hFF, 8'hF1, 8'h0E};
  int                 err_total;
  int                 checks;
  int                 acc_cnt;
  int                 acc_base;

  hap_host_access_port hap_host_access_port_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .spi_en_i(spi_en_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .addr_i(addr_i),
    .data_i(data_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o), .int_n_o(int_n_o),
    .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
    .mem_rdata_i(mem_rdata_i), .irq_i(irq_i));

  hap_host_model hap_host_model_i (.clk_i(clk_i), .rdata_i(data_o),
    .rdata_oe_n_i(data_oe_n_o), .miso_i(miso_o), .miso_oe_n_i(miso_oe_n_o),
    .spi_en_o(spi_en_i), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i),
    .addr_o(addr_i), .wdata_o(data_i));

  // -------------------------------------------------------------------------
  // internal memory model, read data one cycle after the pulse
  // -------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (mem_we_o === 1'b1)
      mem[mem_addr_o] = mem_wdata_o;
    if (!rstn_i)
      mem_rdata_i <= 8'h00;
    else if (mem_re_o === 1'b1)
      mem_rdata_i <= mem.exists(mem_addr_o) ? mem[mem_addr_o] : 8'hEE;
    if (mem_we_o === 1'b1 || mem_re_o === 1'b1)
      acc_cnt++;
  end

  function automatic logic [DATA_W-1:0] mem_at(input logic [IADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 8'hEE;
  endfunction : mem_at

  task automatic chk8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    test_done;
  end

  // -------------------------------------------------------------------------
  // tests
  // -------------------------------------------------------------------------
  initial
  begin
    rstn_i = 1'b0;
    irq_i = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    // direct bus
    hap_host_model_i.par_wr(15'h0123, 8'h5A);
    chk8(mem_at(16'h0123), 8'h5A);
    hap_host_model_i.par_rd(15'h0123, rd);
    chk8(rd, 8'h5A);
    // indirect with auto-increment, upper address lines low
    hap_host_model_i.par_wr(15'h0000, 8'h03);
    hap_host_model_i.par_wr(15'h0001, 8'h04);
    hap_host_model_i.par_wr(15'h0002, 8'h01);
    hap_host_model_i.par_rd(15'h0000, rd);
    chk8(rd, 8'h03);
    hap_host_model_i.par_rd(15'h0001, rd);
    chk8(rd, 8'h04);
    hap_host_model_i.par_rd(15'h0002, rd);
    chk8(rd, 8'h01);
    for (int i = 0; i < 3; i++)
      hap_host_model_i.par_wr(15'h0003, 8'(8'hC0 + i));
    for (int i = 0; i < 3; i++)
      chk8(mem_at(16'(16'h0401 + i)), 8'(8'hC0 + i));
    hap_host_model_i.par_wr(15'h0002, 8'h02);
    hap_host_model_i.par_rd(15'h0003, rd);
    chk8(rd, 8'hC1);
    hap_host_model_i.par_rd(15'h0003, rd);
    chk8(rd, 8'hC2);
    hap_host_model_i.par_wr(15'h0000, 8'h00);
    // interrupt pin follows the core event
    irq_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk8({7'h00, int_n_o}, 8'h00);
    irq_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk8({7'h00, int_n_o}, 8'h01);
    // serial slave
    hap_host_model_i.spi_mode(1'b1);
    chk8({7'h00, miso_oe_n_o}, 8'h01);
    hap_host_model_i.spi_frame(OP_WRITE, 16'h0210, 8'hA5, 32, rd);
    chk8(mem_at(16'h0210), 8'hA5);
    hap_host_model_i.spi_frame(OP_READ, 16'h0210, 8'h00, 32, rd);
    chk8(rd, 8'hA5);
    acc_base = acc_cnt;
    foreach (bad_ops[k])
      hap_host_model_i.spi_frame(bad_ops[k], 16'h0210, 8'h11, 32, rd);
    chk8(8'(acc_cnt - acc_base), 8'h00);
    chk8(mem_at(16'h0210), 8'hA5);
    hap_host_model_i.spi_frame(OP_WRITE, 16'h0210, 8'h77, 20, rd);
    chk8(mem_at(16'h0210), 8'hA5);
    hap_host_model_i.spi_frame(OP_WRITE, 16'h0220, 8'h3C, 32, rd);
    chk8(mem_at(16'h0220), 8'h3C);
    hap_host_model_i.spi_frame(OP_READ, 16'h0220, 8'h00, 32, rd);
    chk8(rd, 8'h3C);
    hap_host_model_i.spi_mode(1'b0);
    test_done;
  end
endmodule : tb_top
